// file: dstp_map.vh
`ifndef DSTP_MAP_VH
`define DSTP_MAP_VH
// Frame and word sizes.
`define DSTP_WORD_BITS 16
`define DSTP_SPI_CNT_W 6
`define DSTP_SPI_MIN_EDGES 6'h10
`define DSTP_SPI_MAX_EDGES 6'h20
// Command field codes (control nibble) that the front end must recognise.
`define DSTP_CTL_READBACK 4'h3
`define DSTP_CTL_COPY_NVM 4'h7
`define DSTP_CTL_WRITE_NVM 4'h8
// I2C target address base and strap codes.
`define DSTP_I2C_BASE 7'h20
`define DSTP_STRAP_HIGH 2'h2
`define DSTP_STRAP_OPEN 2'h1
`define DSTP_STRAP_LOW 2'h0
// Nonvolatile store time, clock rate, and the derived cycle count.
`define DSTP_NVM_STORE_MS 18
`define DSTP_CLK_MHZ 250
`define DSTP_NVM_STORE_CYC 23'h44aa20
`define DSTP_BUSY_W 23
// I2C target states, one-hot.
`define DSTP_ST_IDLE 7'h01
`define DSTP_ST_ADDR 7'h02
`define DSTP_ST_AACK 7'h04
`define DSTP_ST_WR 7'h08
`define DSTP_ST_WACK 7'h10
`define DSTP_ST_RD 7'h20
`define DSTP_ST_RACK 7'h40
`endif

// file: dstp_port.v
// Function
// - Strap low selects the SPI port, strap high selects the I2C target.
// - SPI input is sampled on each serial clock falling edge during a frame.
// - The shifted word is decoded only when frame select rises.
// - Serial clock may stop while frame select is high without harm.
// - Fewer than 16 falling edges discards the frame as invalid.
// - Open-drain serial output, enabled in frame, updated on rising clock edges.
// - Serial output carries readback data and passes shifted data for chaining.
// - Edge count must be a multiple of eight, 16 to 32; cleared at frame end.
// - I2C target works at 100 kHz and 400 kHz bus rates.
// - No response to 10-bit addressing or to the general call address.
// - After start, match the 7-bit address and acknowledge on the ninth clock.
// - Nine clocks per byte; data changes only while the clock is low.
// - Address comes from two three-state straps, nine addresses 0x20 to 0x2f.
// - Write is address with direction 0, two command bytes MSB first, all acked.
// - Several command words may follow one address within a write.
// - After a nonvolatile write, address acknowledge is withheld until done.
// - Readback is a write of the read command, then a read of two bytes.
// - No acknowledge on the first read byte suppresses the second byte.
// - Command words are 16 bits, MSB first: control, address, data nibbles.
// - A nonvolatile store locks the device for about 18 ms.
`timescale 1ns/1ps
`include "dstp_map.vh"
module dstp_port #(
	parameter [`DSTP_BUSY_W-1:0] NVM_STORE_CYCLES = `DSTP_NVM_STORE_CYC
) (
	// Clock and reset.
	input wire core_clk,
	input wire rst_b,
	// Straps.
	input wire interfaceSelectStrap,
	input wire [1:0] addressStrapLow,
	input wire [1:0] addressStrapHigh,
	// SPI pins.
	input wire spiFrameSelB,
	input wire spiSclk,
	input wire spiSdi,
	output wire spiSdoOut,
	output wire spiSdoOe,
	// I2C pins.
	input wire i2cSclIn,
	input wire i2cSdaIn,
	output wire i2cSdaOut,
	output wire i2cSdaOe,
	// Command decoder side.
	output wire [15:0] cmdWord,
	output wire cmdValid,
	input wire [15:0] readbackWord,
	output wire nvmBusy
);
	// Three-flop synchronisers for the serial pins and the interface strap; stage 1 feeds only stage 2.
	reg [5:0] syncA_q;
	reg [5:0] syncB_q;
	reg [5:0] syncC_q;
	reg [5:0] pinF_q;
	wire [5:0] pinRaw = {interfaceSelectStrap, spiFrameSelB, spiSclk, spiSdi, i2cSclIn, i2cSdaIn};
	wire [5:0] pinD = ((syncB_q ~^ syncC_q) & syncB_q) | ((syncB_q ^ syncC_q) & pinF_q);
	// A level counts once stages two and three agree, which also rejects single-sample glitches.
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			syncA_q <= 6'h3f;
			syncB_q <= 6'h3f;
			syncC_q <= 6'h3f;
			pinF_q <= 6'h3f;
		end else begin
			syncA_q <= pinRaw;
			syncB_q <= syncA_q;
			syncC_q <= syncB_q;
			pinF_q <= pinD;
		end
	end
	wire modeI2c = pinF_q[5];
	wire frameB = pinF_q[4];
	wire sclk = pinF_q[3];
	wire sdi = pinF_q[2];
	wire scl = pinF_q[1];
	wire sda = pinF_q[0];
	wire frameFall = pinF_q[4] & ~pinD[4];
	wire frameRise = ~pinF_q[4] & pinD[4];
	wire sclkFall = pinF_q[3] & ~pinD[3] & ~frameB;
	wire sclkRise = ~pinF_q[3] & pinD[3] & ~frameB;
	wire sclRise = ~pinF_q[1] & pinD[1];
	wire sclFall = pinF_q[1] & ~pinD[1];
	wire i2cStart = pinF_q[0] & ~pinD[0] & pinF_q[1] & pinD[1];
	wire i2cStop = ~pinF_q[0] & pinD[0] & pinF_q[1] & pinD[1];

	// Address map of one strap: tied high, open, tied low give 00, 10, 11.
	function [1:0] dstpStrapBits;
		input [1:0] code;
		begin
			case (code)
				`DSTP_STRAP_HIGH: dstpStrapBits = 2'h0;
				`DSTP_STRAP_OPEN: dstpStrapBits = 2'h2;
				default: dstpStrapBits = 2'h3;
			endcase
		end
	endfunction

	// Straps are caught by a clocked process after reset release, not by the reset itself.
	reg [6:0] ownAddr_q;
	reg strapDone_q;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ownAddr_q <= `DSTP_I2C_BASE;
			strapDone_q <= 1'b0;
		end else if (!strapDone_q) begin
			ownAddr_q <= `DSTP_I2C_BASE | {3'h0, dstpStrapBits(addressStrapHigh), dstpStrapBits(addressStrapLow)};
			strapDone_q <= 1'b1;
		end
	end

	// Busy timer for a nonvolatile store; words from either port may start it.
	reg [`DSTP_BUSY_W-1:0] busyCnt_q;
	reg busy_q;
	reg cmdValid_q;
	reg [15:0] cmdWord_q;
	wire [3:0] cmdCtl = cmdWord_q[15:12];
	wire isStore = (cmdCtl == `DSTP_CTL_COPY_NVM && cmdWord_q[0]) || cmdCtl == `DSTP_CTL_WRITE_NVM;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			busyCnt_q <= {`DSTP_BUSY_W{1'b0}};
			busy_q <= 1'b0;
		end else if (cmdValid_q && isStore) begin
			busyCnt_q <= NVM_STORE_CYCLES;
			busy_q <= 1'b1;
		end else if (busyCnt_q != {`DSTP_BUSY_W{1'b0}}) begin
			busyCnt_q <= busyCnt_q - 1'b1;
			busy_q <= (busyCnt_q != {{(`DSTP_BUSY_W-1){1'b0}}, 1'b1});
		end else begin
			busy_q <= 1'b0;
		end
	end

	// SPI shift path. All its logic but the output enable, which follows frame select every cycle, waits on edges of the serial clock or frame select.
	reg [15:0] spiSh_q;
	reg [`DSTP_SPI_CNT_W-1:0] edgeCnt_q;
	reg spiOutBit_q;
	reg spiOe_q;
	reg spiRbPend_q;
	wire [`DSTP_SPI_CNT_W-1:0] edgeNext = (edgeCnt_q == {`DSTP_SPI_CNT_W{1'b1}}) ? edgeCnt_q : edgeCnt_q + 1'b1;
	wire spiGood = edgeCnt_q[2:0] == 3'h0 && edgeCnt_q >= `DSTP_SPI_MIN_EDGES && edgeCnt_q <= `DSTP_SPI_MAX_EDGES;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			spiSh_q <= 16'h0000;
			edgeCnt_q <= {`DSTP_SPI_CNT_W{1'b0}};
			spiOutBit_q <= 1'b1;
			spiOe_q <= 1'b0;
		end else if (modeI2c) begin
			edgeCnt_q <= {`DSTP_SPI_CNT_W{1'b0}};
			spiOe_q <= 1'b0;
		end else begin
			if (frameFall) begin
				edgeCnt_q <= {`DSTP_SPI_CNT_W{1'b0}};
				if (spiRbPend_q) begin
					spiSh_q <= readbackWord;
					spiOutBit_q <= readbackWord[15];
				end else begin
					spiOutBit_q <= spiSh_q[15];
				end
			end else if (sclkFall) begin
				spiSh_q <= {spiSh_q[14:0], sdi};
				edgeCnt_q <= edgeNext;
			end else if (sclkRise) begin
				spiOutBit_q <= spiSh_q[15];
			end
			if (frameRise) begin
				edgeCnt_q <= {`DSTP_SPI_CNT_W{1'b0}};
			end
			// Open drain: only a low bit is driven, and only inside a frame.
			spiOe_q <= ~frameB & ~pinD[4] & ~spiOutBit_q;
		end
	end

	// I2C target state machine.
	reg [6:0] st_q;
	reg [2:0] bitCnt_q;
	reg got8_q;
	reg [7:0] rxSh_q;
	reg [7:0] hiByte_q;
	reg hiDone_q;
	reg [15:0] txSh_q;
	reg firstByte_q;
	reg masterAck_q;
	reg rdArmed_q;
	reg sdaOe_q;
	wire addrHit = rxSh_q[7:1] == ownAddr_q;
	wire addrOk = addrHit && !busy_q && (!rxSh_q[0] || rdArmed_q);
	wire i2cWordDone = modeI2c && (st_q == `DSTP_ST_WR) && sclFall && got8_q && hiDone_q && !busy_q;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= `DSTP_ST_IDLE;
			bitCnt_q <= 3'h0;
			got8_q <= 1'b0;
			rxSh_q <= 8'h00;
			hiByte_q <= 8'h00;
			hiDone_q <= 1'b0;
			txSh_q <= 16'h0000;
			firstByte_q <= 1'b0;
			masterAck_q <= 1'b0;
			sdaOe_q <= 1'b0;
		end else if (!modeI2c || i2cStop) begin
			st_q <= `DSTP_ST_IDLE;
			sdaOe_q <= 1'b0;
		end else if (i2cStart) begin
			st_q <= `DSTP_ST_ADDR;
			bitCnt_q <= 3'h0;
			got8_q <= 1'b0;
			hiDone_q <= 1'b0;
			sdaOe_q <= 1'b0;
		end else if (sclRise) begin
			// Bits are taken while the clock is high, where the line is stable.
			case (st_q)
				`DSTP_ST_ADDR, `DSTP_ST_WR, `DSTP_ST_RD: begin
					rxSh_q <= {rxSh_q[6:0], sda};
					bitCnt_q <= bitCnt_q + 3'h1;
					got8_q <= bitCnt_q == 3'h7;
				end
				`DSTP_ST_RACK: masterAck_q <= ~sda;
				default: begin
				end
			endcase
		end else if (sclFall) begin
			// Drive changes happen only just after the clock falls.
			case (st_q)
				`DSTP_ST_ADDR: if (got8_q) begin
					got8_q <= 1'b0;
					if (addrOk) begin
						st_q <= `DSTP_ST_AACK;
						sdaOe_q <= 1'b1;
					end else begin
						st_q <= `DSTP_ST_IDLE;
					end
				end
				`DSTP_ST_AACK: begin
					if (rxSh_q[0]) begin
						st_q <= `DSTP_ST_RD;
						txSh_q <= readbackWord;
						sdaOe_q <= ~readbackWord[15];
						firstByte_q <= 1'b1;
					end else begin
						st_q <= `DSTP_ST_WR;
						sdaOe_q <= 1'b0;
					end
				end
				`DSTP_ST_WR: if (got8_q) begin
					got8_q <= 1'b0;
					st_q <= `DSTP_ST_WACK;
					sdaOe_q <= 1'b1;
					hiByte_q <= rxSh_q;
					hiDone_q <= ~hiDone_q;
				end
				`DSTP_ST_WACK: begin
					st_q <= `DSTP_ST_WR;
					sdaOe_q <= 1'b0;
				end
				`DSTP_ST_RD: begin
					txSh_q <= {txSh_q[14:0], 1'b0};
					if (got8_q) begin
						got8_q <= 1'b0;
						st_q <= `DSTP_ST_RACK;
						sdaOe_q <= 1'b0;
					end else begin
						sdaOe_q <= ~txSh_q[14];
					end
				end
				`DSTP_ST_RACK: begin
					if (masterAck_q && firstByte_q) begin
						st_q <= `DSTP_ST_RD;
						firstByte_q <= 1'b0;
						sdaOe_q <= ~txSh_q[15];
					end else begin
						st_q <= `DSTP_ST_IDLE;
					end
				end
				default: st_q <= `DSTP_ST_IDLE;
			endcase
		end
	end

	// Word hand-off to the decoder; SPI words wait for frame end, I2C words for the second byte.
	wire spiWordDone = !modeI2c && frameRise && spiGood && !busy_q;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmdWord_q <= 16'h0000;
			cmdValid_q <= 1'b0;
		end else begin
			cmdValid_q <= spiWordDone | i2cWordDone;
			if (spiWordDone) begin
				cmdWord_q <= spiSh_q;
			end else if (i2cWordDone) begin
				cmdWord_q <= {hiByte_q, rxSh_q};
			end
		end
	end

	// Readback arming: one read per readback command, never repeated.
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdArmed_q <= 1'b0;
			spiRbPend_q <= 1'b0;
		end else begin
			if (cmdValid_q && cmdCtl == `DSTP_CTL_READBACK) begin
				rdArmed_q <= modeI2c;
				spiRbPend_q <= !modeI2c;
			end else begin
				if (st_q == `DSTP_ST_AACK && sclFall && rxSh_q[0]) begin
					rdArmed_q <= 1'b0;
				end
				if (frameFall) begin
					spiRbPend_q <= 1'b0;
				end
			end
		end
	end

	// Output levels of open-drain pins stay low; only the enables move.
	reg lowLevel_q;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lowLevel_q <= 1'b0;
		end else begin
			lowLevel_q <= 1'b0;
		end
	end

	// Output assignments, each from a flip-flop.
	assign spiSdoOut = lowLevel_q;
	assign spiSdoOe = spiOe_q;
	assign i2cSdaOut = lowLevel_q;
	assign i2cSdaOe = sdaOe_q;
	assign cmdWord = cmdWord_q;
	assign cmdValid = cmdValid_q;
	assign nvmBusy = busy_q;
endmodule

// file: dstp_asserts.sv
`timescale 1ns/1ps
`include "dstp_map.vh"
module dstp_asserts #(
	parameter [`DSTP_BUSY_W-1:0] NVM_STORE_CYCLES = 23'h0000c8
) (
	// Clock and reset.
	input wire core_clk,
	input wire rst_b,
	// Pins and decoder side.
	input wire interfaceSelectStrap,
	input wire spiFrameSelB,
	input wire spiSdoOut,
	input wire spiSdoOe,
	input wire i2cSdaOut,
	input wire i2cSdaOe,
	input wire [15:0] cmdWord,
	input wire cmdValid,
	input wire nvmBusy
);
	reg [`DSTP_BUSY_W-1:0] busyCnt_q;
	// Counts lock cycles so that a lock one cycle short or long is caught.
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			busyCnt_q <= 23'h0;
		else
			busyCnt_q <= nvmBusy ? busyCnt_q + 23'h1 : 23'h0;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	property p_sdo_idle; spiFrameSelB [*8] |-> !spiSdoOe; endproperty
	a_sdo_idle: assert property (p_sdo_idle) else $error("SDO driven outside a frame");
	property p_drive_low; !spiSdoOut && !i2cSdaOut; endproperty
	a_drive_low: assert property (p_drive_low) else $error("Open-drain output drives high");
	property p_i2c_off; !interfaceSelectStrap [*8] |-> !i2cSdaOe; endproperty
	a_i2c_off: assert property (p_i2c_off) else $error("SDA pulled in SPI mode");
	property p_spi_off; interfaceSelectStrap [*8] |-> !spiSdoOe; endproperty
	a_spi_off: assert property (p_spi_off) else $error("SDO driven in I2C mode");
	property p_after_rise; cmdValid && !interfaceSelectStrap |-> spiFrameSelB && $past(spiFrameSelB, 3); endproperty
	a_after_rise: assert property (p_after_rise) else $error("SPI word issued inside a frame");
	property p_busy_go;
		cmdValid && !nvmBusy && (cmdWord[15:12] == 4'h8 || (cmdWord[15:12] == 4'h7 && cmdWord[0])) |=> nvmBusy;
	endproperty
	a_busy_go: assert property (p_busy_go) else $error("Store did not lock");
	property p_busy_len; $fell(nvmBusy) |-> busyCnt_q == NVM_STORE_CYCLES; endproperty
	a_busy_len: assert property (p_busy_len) else $error("Lock length wrong");
	property p_busy_quiet; nvmBusy |-> !cmdValid; endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("Word taken while locked");
	c_spi: cover property (cmdValid && !interfaceSelectStrap);
	c_i2c: cover property (cmdValid && interfaceSelectStrap);
	c_ack: cover property ($rose(i2cSdaOe));
	c_lock: cover property ($rose(nvmBusy));
endmodule
bind dstp_port dstp_asserts #(.NVM_STORE_CYCLES(NVM_STORE_CYCLES)) i_dstp_asserts (.core_clk(core_clk),
	.rst_b(rst_b), .interfaceSelectStrap(interfaceSelectStrap), .spiFrameSelB(spiFrameSelB),
	.spiSdoOut(spiSdoOut), .spiSdoOe(spiSdoOe), .i2cSdaOut(i2cSdaOut), .i2cSdaOe(i2cSdaOe),
	.cmdWord(cmdWord), .cmdValid(cmdValid), .nvmBusy(nvmBusy));

// file: dstp_ctrl.sv
`timescale 1ns/1ps
module dstp_ctrl (
	// SPI pins; the controller drives all but sdoLine, which it reads.
	output logic spiFrameSelB,
	output logic spiSclk,
	output logic spiSdi,
	input wire sdoLine,
	// I2C pins; sdaRel high lets the pull-up win.
	output logic i2cScl,
	output logic sdaRel,
	input wire sdaLine
);
	int Q = 60;
	// Serial clocks stand still high between frames.
	initial begin
		spiFrameSelB = 1'b1;
		spiSclk = 1'b1;
		spiSdi = 1'b0;
		i2cScl = 1'b1;
		sdaRel = 1'b1;
	end
	// One frame of n bits; SDO is read late in each low phase, well after the rising edge.
	task automatic spiFrame(input logic [31:0] d, input int n, output logic [31:0] so);
		so = 32'h0;
		spiFrameSelB = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			// Data settles half a period before the falling edge that takes it.
			spiSdi = (i < 32) ? d[i] : 1'b0;
			#24;
			spiSclk = 1'b0;
			#24;
			if (i < 32)
				so[i] = sdoLine;
			spiSclk = 1'b1;
		end
		#24;
		spiSdi = ~spiSdi;
		spiFrameSelB = 1'b1;
		#120;
	endtask
	// A start: SDA falls while SCL is high.
	task automatic i2cStart;
		sdaRel = 1'b1;
		i2cScl = 1'b1;
		#Q;
		sdaRel = 1'b0;
		#Q;
		i2cScl = 1'b0;
		#Q;
	endtask
	// Nine clocks per byte; SDA only moves a quarter period after SCL falls.
	task automatic i2cXfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sdaRel = tx[i];
			#Q;
			i2cScl = 1'b1;
			#Q;
			rx[i] = sdaLine;
			#Q;
			i2cScl = 1'b0;
			#Q;
		end
	endtask
	// A stop: SDA rises while SCL is high.
	task automatic i2cStop;
		sdaRel = 1'b0;
		#Q;
		i2cScl = 1'b1;
		#Q;
		sdaRel = 1'b1;
		#Q;
	endtask
endmodule

// file: tb_dual_serial_target_port.sv
`timescale 1ns/1ps
module tb_dual_serial_target_port;
	logic core_clk = 1'b0;
	logic rstB = 1'b0;
	logic strap = 1'b0;
	logic [1:0] strapLo = 2'h2;
	logic [1:0] strapHi = 2'h2;
	logic [15:0] rbWord = 16'h0;
	wire frameB, sclk, sdi, sdoOut, sdoOe, scl, sdaRel, sdaOut, sdaOe, cmdValid, nvmBusy;
	wire [15:0] cmdWord;
	wire sdaLine = sdaRel & ~(sdaOe & ~sdaOut);
	wire sdoLine = ~(sdoOe & ~sdoOut);
	int numErrors = 0;
	int checksDone = 0;
	int cycles = 0;
	logic [15:0] words[$];
	logic [8:0] rx;
	logic [6:0] adr;
	dstp_port #(.NVM_STORE_CYCLES(23'h0007d0)) i_dstp_port (.core_clk(core_clk), .rst_b(rstB),
		.interfaceSelectStrap(strap), .addressStrapLow(strapLo), .addressStrapHigh(strapHi),
		.spiFrameSelB(frameB), .spiSclk(sclk), .spiSdi(sdi), .spiSdoOut(sdoOut), .spiSdoOe(sdoOe),
		.i2cSclIn(scl), .i2cSdaIn(sdaLine), .i2cSdaOut(sdaOut), .i2cSdaOe(sdaOe),
		.cmdWord(cmdWord), .cmdValid(cmdValid), .readbackWord(rbWord), .nvmBusy(nvmBusy));
	dstp_ctrl i_dstp_ctrl (.spiFrameSelB(frameB), .spiSclk(sclk), .spiSdi(sdi), .sdoLine(sdoLine),
		.i2cScl(scl), .sdaRel(sdaRel), .sdaLine(sdaLine));
	initial forever #2 core_clk = ~core_clk;
	// Records issued words; the cycle ceiling turns a hang into a failed run.
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cmdValid === 1'b1)
			words.push_back(cmdWord);
		if (cycles == 60000) begin
			numErrors++;
			endSim();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checksDone++;
		if (g !== e) begin
			numErrors++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic expWords(input int n, input logic [15:0] w);
		repeat (40) @(negedge core_clk);
		chk(words.size(), n);
		if (n > 0 && words.size() > 0)
			chk(words[0], w);
		words.delete();
	endtask
	task automatic doRst;
		@(negedge core_clk);
		rstB = 1'b0;
		repeat (16) @(negedge core_clk);
		rstB = 1'b1;
		repeat (8) @(negedge core_clk);
	endtask
	task automatic spi(input logic [31:0] d, input int n, input int expN, output logic [31:0] so);
		i_dstp_ctrl.spiFrame(d, n, so);
		expWords(expN, d[15:0]);
	endtask
	task automatic addrOnly(input logic [7:0] b, output logic nak);
		i_dstp_ctrl.i2cStart();
		i_dstp_ctrl.i2cXfer({b, 1'b1}, rx);
		nak = rx[0];
	endtask
	// Sends one word as two bytes, high byte first, and checks that it is issued.
	task automatic i2cWord(input logic [15:0] w, output logic nak);
		logic [8:0] r2;
		i_dstp_ctrl.i2cXfer({w[15:8], 1'b1}, rx);
		i_dstp_ctrl.i2cXfer({w[7:0], 1'b1}, r2);
		nak = rx[0] | r2[0];
		expWords(1, w);
	endtask
	task automatic cmd(input logic [15:0] w);
		logic n1;
		logic n2;
		addrOnly({adr, 1'b0}, n1);
		i2cWord(w, n2);
		i_dstp_ctrl.i2cStop();
		chk(n1 | n2, 0);
	endtask
	task automatic rd(input logic nakBit, output logic [7:0] d);
		i_dstp_ctrl.i2cXfer({8'hff, nakBit}, rx);
		d = rx[8:1];
	endtask
	function automatic logic [1:0] m(input logic [1:0] c);
		return (c == 2'h2) ? 2'h0 : (c == 2'h1) ? 2'h2 : 2'h3;
	endfunction
	task automatic endSim;
		$display("checks %0d mismatches %0d", checksDone, numErrors);
		if (numErrors == 0 && checksDone > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		logic [31:0] so;
		logic [31:0] d;
		logic [7:0] hi;
		logic [7:0] lo;
		logic nak;
		void'($urandom(32'h3f0b6162));
		doRst();
		d = ($urandom & 32'hffff0fff) | 32'h2000;
		spi(d, 16, 1, so);
		rbWord = $urandom;
		spi(32'h00003003, 16, 1, so);
		d = ($urandom & 32'hffff0fff) | 32'h1000;
		spi(d, 32, 1, so);
		chk(so, {rbWord, d[31:16]});
		spi(d & 32'h00ffffff, 24, 1, so);
		for (int n = 8; n < 34; n += 5)
			spi($urandom, n, 0, so);
		spi(32'h00008000 | 32'($urandom & 8'hff), 16, 1, so);
		spi(d, 16, 0, so);
		repeat (2100) @(negedge core_clk);
		spi(d, 16, 1, so);
		$display("spi test done");
		strap = 1'b1;
		for (int k = 0; k < 9; k++) begin
			strapHi = 2'(k / 3);
			strapLo = 2'(k % 3);
			doRst();
			adr = {3'h2, m(strapHi), m(strapLo)};
			addrOnly({adr, 1'b0}, nak);
			i_dstp_ctrl.i2cStop();
			chk(nak, 0);
		end
		for (int i = 0; i < 3; i++) begin
			addrOnly({(i == 0) ? adr ^ 7'h01 : (i == 1) ? 7'h00 : 7'h78, 1'b0}, nak);
			i_dstp_ctrl.i2cStop();
			chk(nak, 1);
		end
		i_dstp_ctrl.Q = 625;
		addrOnly({adr, 1'b0}, nak);
		i_dstp_ctrl.i2cStop();
		chk(nak, 0);
		i_dstp_ctrl.Q = 60;
		addrOnly({adr, 1'b0}, nak);
		for (int j = 0; j < 3; j++) begin
			i2cWord(16'h1000 | 16'($urandom & 12'hfff), hi[0]);
			chk(hi[0], 0);
		end
		i_dstp_ctrl.i2cStop();
		rbWord = $urandom;
		cmd(16'h3003);
		addrOnly({adr, 1'b1}, nak);
		rd(1'b0, hi);
		rd(1'b1, lo);
		i_dstp_ctrl.i2cStop();
		chk({nak, hi, lo}, {1'b0, rbWord});
		addrOnly({adr, 1'b1}, nak);
		i_dstp_ctrl.i2cStop();
		chk(nak, 1);
		cmd(16'h3003);
		addrOnly({adr, 1'b1}, nak);
		rd(1'b1, hi);
		rd(1'b1, lo);
		i_dstp_ctrl.i2cStop();
		chk({hi, lo}, {rbWord[15:8], 8'hff});
		$display("i2c test done");
		cmd(16'h7001);
		for (int p = 0; p < 12; p++) begin
			addrOnly({adr, 1'b0}, nak);
			i_dstp_ctrl.i2cStop();
			if (p == 0)
				chk(nak, 1);
			if (!nak)
				break;
		end
		chk(nak, 0);
		$display("store lock test done");
		endSim();
	end
endmodule
